// File: rtl/uarx_consts.vh
// Constants for the serial receive qualification block.
// Assumes an includer working on a 40 MHz system clock.
`ifndef UARX_CONSTS_VH
`define UARX_CONSTS_VH

// ----------------------------------------
// Modes
// ----------------------------------------
`define UARX_MODE_SHIFT 2'h0
`define UARX_MODE_ASYNC8 2'h1
`define UARX_MODE_OSC9 2'h2
`define UARX_MODE_TMR9 2'h3

// ----------------------------------------
// Dividers and oversampling
// ----------------------------------------
`define UARX_DIV_SLOW 8'h0C
`define UARX_DIV_FAST 8'h04
`define UARX_OSC_PRE 2'h1
`define UARX_OSC_PRE_DBL 2'h0
`define UARX_OVS_HALF 5'h07
`define UARX_OVS_FULL 5'h1F
`define UARX_OVS_MID 5'h0F
`define UARX_TMR_FULL 9'h100

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define UARX_BITS_ASYNC8 4'h9
`define UARX_BITS_NINE 4'hA
`define UARX_BITS_SHIFT 4'h8
`define UARX_ADDR_RESET 8'h00

// ----------------------------------------
// Buffering
// ----------------------------------------
`define UARX_FIFO_WIDTH 9
`define UARX_FIFO_DEPTH 16
`define UARX_FIFO_AW 4

`endif

// File: rtl/uarx_fifo.v
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module uarx_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire srst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    wire push;
    wire pop;

    assign in_ready = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ----------------------------------------
    // Storage and pointers
    // ----------------------------------------
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

// File: rtl/uarx_rx.v
// Serial receive path with baud selection, framing check and address filter.
// Assumes rx_pin is already synchronous to clk; timer1_ovf is a one-cycle pulse.
//
// Behaviour
// - Nine-bit modes load buffer, ninth bit, set done when done clear and qualified
// - Failing frames are dropped; done stays low; wait for next falling edge
// - Mode 3 equals mode 2 except its tick comes from timer 1 overflow
// - Shift mode rate is clock/12, or clock/4 with multiprocessor enable
// - Modes 1 and 3 rate uses 256 minus reload, divisor 12 or 4
// - Timer reload value is the timer 1 high byte
// - Baud double bit doubles timer-derived rate
// - Framing check runs in modes 1, 2, 3 on stop bit low
// - Frame error flag is sticky; only software write clears it
// - Control bit 7 maps to frame error or mode bit 0, stored apart
// - With multiprocessor enable, nine-bit modes report only ninth-bit-one frames
// - Multiprocessor enable does not filter shift mode reception; there it only selects the rate
// - Mode 1 with enable reports only frames with valid stop bit
// - With enable set, address frames report only on address match
// - Mode 1 address recognition uses stop bit as ninth bit
// - Given address is own address AND mask; mask zeros ignored
// - Broadcast address is own OR mask; its zeros are don't-care
// - Own address and mask reset to zero so every address matches
// - Nine-bit frame is start, eight data LSB first, ninth, stop
// - Mode 2 rate is clock/64, or clock/32 when doubled
`timescale 1ns/100ps
`include "uarx_consts.vh"
module uarx_rx (
    input wire clk,
    input wire srst,
    input wire rx_pin,
    input wire rx_enable,
    input wire timer1_ovf,
    input wire [7:0] timer1_reload_byte,
    input wire baud_double,
    input wire frame_err_enable,
    input wire timer1_fast_clock,
    input wire ctl_bit7_wr,
    input wire ctl_bit7_wdata,
    input wire [1:0] mode_wdata,
    input wire mode_wr,
    input wire multiproc_enable,
    input wire rx_done_clr,
    input wire [7:0] own_slave_address,
    input wire [7:0] slave_address_mask,
    input wire addr_wr,
    input wire rd_ready,
    output reg ctl_bit7_rdata,
    output reg [1:0] serial_mode,
    output reg rx_done_flag,
    output reg rx_ninth_bit,
    output reg [7:0] serial_buffer,
    output reg frame_err_flag,
    output reg rx_busy,
    output reg rx_tick,
    output reg [7:0] rd_data,
    output reg rd_ninth,
    output reg rd_valid,
    output reg rx_overrun
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_END = 2'h3;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg serial_mode_bit0_ff;
    reg serial_mode_bit1_ff;
    reg [7:0] own_slave_address_ff;
    reg [7:0] slave_address_mask_ff;
    reg [7:0] pre_ff;
    reg [8:0] tmr_ff;
    reg [4:0] ovs_ff;
    reg [3:0] bit_cnt_ff;
    reg [9:0] shift_ff;
    reg rx_prev_ff;
    reg [1:0] mode2_pre_ff;
    reg tick;
    reg [1:0] mode;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [8:0] fifo_out_data;
    reg fifo_push;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function addr_match;
        input [7:0] rx_addr;
        input [7:0] own;
        input [7:0] mask;
        reg [7:0] given;
        reg [7:0] bcast;
        begin
            given = own & mask;
            bcast = own | mask;
            // Mask zeros are don't-care on the given comparison; broadcast zeros on the broadcast one
            addr_match = (((rx_addr ^ given) & mask) == 8'h00) ||
                (((rx_addr ^ bcast) & bcast) == 8'h00);
        end
    endfunction

    // ----------------------------------------
    // Mode and bit 7 storage
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            serial_mode_bit0_ff <= 1'b0;
            serial_mode_bit1_ff <= 1'b0;
            own_slave_address_ff <= `UARX_ADDR_RESET;
            slave_address_mask_ff <= `UARX_ADDR_RESET;
        end else begin
            if (mode_wr) begin
                serial_mode_bit0_ff <= mode_wdata[0];
                serial_mode_bit1_ff <= mode_wdata[1];
            end
            // Bit 7 write lands on mode bit 0 only when error access is off
            if (ctl_bit7_wr && !frame_err_enable) begin
                serial_mode_bit0_ff <= ctl_bit7_wdata;
            end
            if (addr_wr) begin
                own_slave_address_ff <= own_slave_address;
                slave_address_mask_ff <= slave_address_mask;
            end
        end
    end

    always @* begin
        mode = {serial_mode_bit0_ff, serial_mode_bit1_ff};
    end

    // ----------------------------------------
    // Baud tick, 16x oversampled for async
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            pre_ff <= 8'h00;
            tmr_ff <= 9'h000;
            mode2_pre_ff <= 2'h0;
        end else begin
            // Shift mode: clock/12 or clock/4; enable bit ignored elsewhere
            if (pre_ff >= ((mode == `UARX_MODE_SHIFT && multiproc_enable) ?
                    `UARX_DIV_FAST : `UARX_DIV_SLOW) - 8'h01) begin
                pre_ff <= 8'h00;
            end else begin
                pre_ff <= pre_ff + 8'h01;
            end
            // Overflow already carries reload and prescale; count for halving
            if (timer1_ovf) begin
                tmr_ff <= tmr_ff + 9'h001;
            end
            mode2_pre_ff <= mode2_pre_ff + 2'h1;
        end
    end

    always @* begin
        case (mode)
            `UARX_MODE_SHIFT: tick = (pre_ff == 8'h00);
            // Oscillator rate /64, doubled to /32: 16x oversample at clock/4 or /2
            `UARX_MODE_OSC9: tick = baud_double ?
                ({1'b0, mode2_pre_ff[0]} == `UARX_OSC_PRE_DBL) :
                (mode2_pre_ff == `UARX_OSC_PRE);
            // Timer modes: external overflow, slow or fast prescale, 32 or 16 overflows per bit
            `UARX_MODE_ASYNC8,
            `UARX_MODE_TMR9: tick = timer1_ovf && (baud_double || tmr_ff[0]);
            default: tick = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Receive state machine
    // ----------------------------------------
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (rx_enable && rx_prev_ff && !rx_pin) nxt_state = ST_START;
            ST_START: if (tick && ovs_ff == `UARX_OVS_HALF) nxt_state = rx_pin ? ST_IDLE : ST_DATA;
            ST_DATA: if (tick && ovs_ff == `UARX_OVS_MID && bit_cnt_ff ==
                ((mode == `UARX_MODE_ASYNC8) ? `UARX_BITS_ASYNC8 - 4'h1 :
                `UARX_BITS_NINE - 4'h1)) nxt_state = ST_END;
            ST_END: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
            ovs_ff <= 5'h00;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 10'h000;
            rx_prev_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            rx_prev_ff <= rx_pin;
            if (state_ff == ST_IDLE) begin
                ovs_ff <= 5'h00;
                bit_cnt_ff <= 4'h0;
            end else if (tick) begin
                // Half period of oversampling wraps first, then full bits
                if (ovs_ff == ((state_ff == ST_START) ? `UARX_OVS_HALF : `UARX_OVS_MID)) begin
                    ovs_ff <= 5'h00;
                    if (state_ff == ST_DATA) begin
                        shift_ff <= {rx_pin, shift_ff[9:1]};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                end else begin
                    ovs_ff <= ovs_ff + 5'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // Frame end qualification
    // ----------------------------------------
    reg [7:0] frm_data;
    reg frm_ninth;
    reg frm_stop;
    reg frm_match;
    reg frm_load;
    always @* begin
        // Async8 keeps stop in bit 9; nine-bit keeps stop in 9, ninth in 8 and data below
        if (mode == `UARX_MODE_ASYNC8) begin
            frm_data = shift_ff[8:1];
            frm_ninth = shift_ff[9];
            frm_stop = shift_ff[9];
        end else begin
            frm_data = shift_ff[7:0];
            frm_ninth = shift_ff[8];
            frm_stop = shift_ff[9];
        end
        frm_match = addr_match(frm_data, own_slave_address_ff, slave_address_mask_ff);
        frm_load = !rx_done_flag && (!multiproc_enable || (mode == `UARX_MODE_SHIFT) ||
            (frm_ninth && frm_match));
    end

    always @(posedge clk) begin
        if (srst) begin
            rx_done_flag <= 1'b0;
            rx_ninth_bit <= 1'b0;
            serial_buffer <= 8'h00;
            frame_err_flag <= 1'b0;
            fifo_push <= 1'b0;
        end else begin
            fifo_push <= 1'b0;
            if (state_ff == ST_END && frm_load) begin
                serial_buffer <= frm_data;
                rx_ninth_bit <= frm_ninth;
                rx_done_flag <= 1'b1;
                fifo_push <= fifo_in_ready;
            end else if (rx_done_clr) begin
                rx_done_flag <= 1'b0;
            end
            // Sticky: only write with error access enabled clears it; set wins
            if (state_ff == ST_END && !frm_stop && mode != `UARX_MODE_SHIFT) begin
                frame_err_flag <= 1'b1;
            end else if (ctl_bit7_wr && frame_err_enable && !ctl_bit7_wdata) begin
                frame_err_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            ctl_bit7_rdata <= 1'b0;
            serial_mode <= 2'h0;
            rx_busy <= 1'b0;
            rx_tick <= 1'b0;
            rd_data <= 8'h00;
            rd_ninth <= 1'b0;
            rd_valid <= 1'b0;
            rx_overrun <= 1'b0;
        end else begin
            ctl_bit7_rdata <= frame_err_enable ? frame_err_flag : serial_mode_bit0_ff;
            serial_mode <= mode;
            rx_busy <= (state_ff != ST_IDLE);
            rx_tick <= tick;
            // Skid-free pop: present one word, drop valid on accept
            if (rd_valid && rd_ready) begin
                rd_valid <= 1'b0;
            end else if (!rd_valid && fifo_out_valid) begin
                rd_data <= fifo_out_data[7:0];
                rd_ninth <= fifo_out_data[8];
                rd_valid <= 1'b1;
            end
            // A qualified frame lost to a full FIFO is reported, not stored
            rx_overrun <= (state_ff == ST_END && frm_load && !fifo_in_ready);
        end
    end

    wire fifo_pop_ready;
    assign fifo_pop_ready = !rd_valid;

    uarx_fifo #(
        .WIDTH(`UARX_FIFO_WIDTH),
        .DEPTH(`UARX_FIFO_DEPTH),
        .AW(`UARX_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data({rx_ninth_bit, serial_buffer}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop_ready),
        .out_data(fifo_out_data)
    );
endmodule

// File: test/uarx_rx_props.sv
// Port-level checks for the serial receive block.
// Assumes one clock, srst synchronous active high; bound to uarx_rx.
`timescale 1ns/100ps
module uarx_rx_props (
    input wire clk,
    input wire srst,
    input wire frame_err_enable,
    input wire ctl_bit7_wr,
    input wire ctl_bit7_wdata,
    input wire multiproc_enable,
    input wire rx_done_clr,
    input wire [7:0] own_slave_address,
    input wire [7:0] slave_address_mask,
    input wire addr_wr,
    input wire rd_ready,
    input wire ctl_bit7_rdata,
    input wire [1:0] serial_mode,
    input wire rx_done_flag,
    input wire rx_ninth_bit,
    input wire [7:0] serial_buffer,
    input wire frame_err_flag,
    input wire [7:0] rd_data,
    input wire rd_ninth,
    input wire rd_valid
);
    // ----------------------------------------
    // Shadow of the address filter
    // ----------------------------------------
    reg [7:0] own_ff;
    reg [7:0] mask_ff;
    wire [7:0] bcast = own_ff | mask_ff;
    wire given_hit = ((serial_buffer ^ own_ff) & mask_ff) == 8'h00;
    wire bcast_hit = (serial_buffer & bcast) == bcast;
    wire fe_clear = ctl_bit7_wr && frame_err_enable && !ctl_bit7_wdata;
    always @(posedge clk) begin
        if (srst) begin
            own_ff <= 8'h00;
            mask_ff <= 8'h00;
        end else if (addr_wr) begin
            own_ff <= own_slave_address;
            mask_ff <= slave_address_mask;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // Load taken while the filter was armed in an async mode
    sequence s_filtered_load;
        $rose(rx_done_flag) && $past(multiproc_enable) && (serial_mode != 2'h0);
    endsequence
    done_hold_a: assert property (rx_done_flag && !rx_done_clr |=> rx_done_flag)
        else $error("Receive-done dropped without a clear");
    buffer_frozen_a: assert property (rx_done_flag && !rx_done_clr |=>
        $stable(serial_buffer) && $stable(rx_ninth_bit))
        else $error("Buffer reloaded while receive-done was set");
    buffer_cause_a: assert property (!$stable(serial_buffer) |-> rx_done_flag)
        else $error("Buffer changed without receive-done");
    fe_sticky_a: assert property (frame_err_flag && !fe_clear |=> frame_err_flag)
        else $error("Frame error flag cleared by hardware");
    fe_async_a: assert property ($rose(frame_err_flag) |-> serial_mode != 2'h0)
        else $error("Frame error raised in shift mode");
    bit7_view_a: assert property (frame_err_enable && $past(frame_err_enable)
        && $stable(frame_err_flag) |-> ctl_bit7_rdata == frame_err_flag)
        else $error("Control bit 7 does not show the frame error flag");
    ninth_one_a: assert property (s_filtered_load |-> rx_ninth_bit)
        else $error("Filtered load with ninth or stop bit low");
    addr_match_a: assert property (s_filtered_load |-> given_hit || bcast_hit)
        else $error("Filtered load of a foreign address");
    stream_hold_a: assert property (rd_valid && !rd_ready |=>
        rd_valid && $stable({rd_ninth, rd_data}))
        else $error("Read stream changed while stalled");
    cover property (s_filtered_load);
endmodule

bind uarx_rx uarx_rx_props uarx_rx_props_inst (
    .clk(clk), .srst(srst), .frame_err_enable(frame_err_enable),
    .ctl_bit7_wr(ctl_bit7_wr), .ctl_bit7_wdata(ctl_bit7_wdata),
    .multiproc_enable(multiproc_enable), .rx_done_clr(rx_done_clr),
    .own_slave_address(own_slave_address), .slave_address_mask(slave_address_mask),
    .addr_wr(addr_wr), .rd_ready(rd_ready), .ctl_bit7_rdata(ctl_bit7_rdata),
    .serial_mode(serial_mode), .rx_done_flag(rx_done_flag), .rx_ninth_bit(rx_ninth_bit),
    .serial_buffer(serial_buffer), .frame_err_flag(frame_err_flag), .rd_data(rd_data),
    .rd_ninth(rd_ninth), .rd_valid(rd_valid)
);

// File: test/uarx_node_model.sv
// Remote serial node that drives the shared receive line.
// Assumes calls start right after a rising clock edge.
`timescale 1ns/100ps
module uarx_node_model (
    input wire clk,
    output reg line
);
    initial line = 1'b1;
    // Start low, data LSB first, ninth bit if nine, stop, then one idle bit
    task send_frame;
        input [7:0] data;
        input ninth;
        input nine;
        input stop;
        input integer per;
        reg [10:0] bits;
        integer i;
        begin
            bits = nine ? {stop, ninth, data, 1'b0} : {1'b1, stop, data, 1'b0};
            for (i = 0; i < (nine ? 11 : 10); i = i + 1) begin
                line <= bits[i];
                repeat (per) @(posedge clk);
            end
            // Pulled high between frames so the next start edge is clean
            line <= 1'b1;
            repeat (per) @(posedge clk);
        end
    endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the serial receive block with a line node model.
// Assumes the checker binds itself to uarx_rx; 40 MHz clock.
`timescale 1ns/100ps
`include "uarx_consts.vh"
module tb_top;
    localparam integer TIME_LIMIT = 90000;
    reg clk, srst, rx_enable, timer1_ovf, baud_double, frame_err_enable, timer1_fast_clock;
    reg ctl_bit7_wr, ctl_bit7_wdata, mode_wr, multiproc_enable, rx_done_clr, addr_wr, rd_ready;
    reg [1:0] mode_wdata;
    reg [7:0] timer1_reload_byte, own_slave_address, slave_address_mask, d;
    reg [8:0] exp_q[$];
    wire rx_pin, ctl_bit7_rdata, rx_done_flag, rx_ninth_bit, frame_err_flag;
    wire rx_busy, rx_tick, rd_ninth, rd_valid, rx_overrun;
    wire [1:0] serial_mode;
    wire [7:0] serial_buffer, rd_data;
    // Overflow spacing of an 8-bit auto-reload timer
    wire [15:0] ovf_per = (timer1_fast_clock ? `UARX_DIV_FAST : `UARX_DIV_SLOW)
        * (16'h0100 - timer1_reload_byte);
    integer error_cnt, cmp_count, seed, cyc, ovf_cnt, ovr_cnt, mode, k, hold_rd, keep_done;

    uarx_rx uarx_rx_inst (
        .clk(clk), .srst(srst), .rx_pin(rx_pin), .rx_enable(rx_enable),
        .timer1_ovf(timer1_ovf), .timer1_reload_byte(timer1_reload_byte),
        .baud_double(baud_double), .frame_err_enable(frame_err_enable),
        .timer1_fast_clock(timer1_fast_clock), .ctl_bit7_wr(ctl_bit7_wr),
        .ctl_bit7_wdata(ctl_bit7_wdata), .mode_wdata(mode_wdata), .mode_wr(mode_wr),
        .multiproc_enable(multiproc_enable), .rx_done_clr(rx_done_clr),
        .own_slave_address(own_slave_address), .slave_address_mask(slave_address_mask),
        .addr_wr(addr_wr), .rd_ready(rd_ready), .ctl_bit7_rdata(ctl_bit7_rdata),
        .serial_mode(serial_mode), .rx_done_flag(rx_done_flag), .rx_ninth_bit(rx_ninth_bit),
        .serial_buffer(serial_buffer), .frame_err_flag(frame_err_flag), .rx_busy(rx_busy),
        .rx_tick(rx_tick), .rd_data(rd_data), .rd_ninth(rd_ninth), .rd_valid(rd_valid),
        .rx_overrun(rx_overrun)
    );
    uarx_node_model uarx_node_model_inst (
        .clk(clk),
        .line(rx_pin)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task check;
        input [8*12:1] name;
        input [8:0] seen;
        input [8:0] exp;
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (error_cnt == 0 && cmp_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Clocks per bit for the selected mode
    function integer bit_per;
        input integer m;
        begin
            if (m == 2)
                bit_per = baud_double ? 32 : 64;
            else
                bit_per = (baud_double ? 16 : 32) * ovf_per;
        end
    endfunction
    function addr_ok;
        input [7:0] a;
        reg [7:0] b;
        begin
            b = own_slave_address | slave_address_mask;
            addr_ok = (((a ^ own_slave_address) & slave_address_mask) == 8'h00)
                || ((a & b) == b);
        end
    endfunction
    // ----------------------------------------
    // Stimulus tasks
    // ----------------------------------------
    task set_mode;
        input integer m;
        begin
            mode = m;
            mode_wdata <= {m[0], m[1]};
            mode_wr <= 1'b1;
            @(posedge clk);
            mode_wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task set_addr;
        input [7:0] o;
        input [7:0] m;
        begin
            own_slave_address <= o;
            slave_address_mask <= m;
            addr_wr <= 1'b1;
            @(posedge clk);
            addr_wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task clear_fe;
        begin
            ctl_bit7_wdata <= 1'b0;
            ctl_bit7_wr <= 1'b1;
            @(posedge clk);
            ctl_bit7_wr <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    // Expected word queued first: the stream can beat the flag check
    task frame;
        input [7:0] dd;
        input n9;
        input stp;
        input expl;
        begin
            rx_done_clr <= !keep_done;
            @(posedge clk);
            rx_done_clr <= 1'b0;
            if (expl)
                exp_q.push_back({(mode == 1) ? stp : n9, dd});
            uarx_node_model_inst.send_frame(dd, n9, mode != 1, stp, bit_per(mode));
            repeat (8) @(posedge clk);
            check("done", rx_done_flag, expl | keep_done);
            if (expl)
                check("buffer", {rx_ninth_bit, serial_buffer}, {(mode == 1) ? stp : n9, dd});
        end
    endtask
    // ----------------------------------------
    // Timer, read stream monitor, watchdog
    // ----------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ovf_cnt <= (ovf_cnt + 1 >= ovf_per) ? 0 : ovf_cnt + 1;
        timer1_ovf <= (ovf_cnt + 1 >= ovf_per);
        if (rx_overrun === 1'b1) begin
            ovr_cnt = ovr_cnt + 1;
            void'(exp_q.pop_back());
        end
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            if (exp_q.size() == 0)
                check("extra_word", 9'h000, 9'h1FF);
            else
                check("stream", {rd_ninth, rd_data}, exp_q.pop_front());
        end
        rd_ready <= (hold_rd == 0) && ($random(seed) & 1);
        if (cyc == TIME_LIMIT) begin
            error_cnt = error_cnt + 1;
            tally_and_finish;
        end
    end

    initial begin
        {srst, rx_enable} = 2'b11;
        {timer1_ovf, baud_double, frame_err_enable, ctl_bit7_wr, ctl_bit7_wdata} = 5'h00;
        {mode_wr, multiproc_enable, rx_done_clr, addr_wr, rd_ready} = 5'h00;
        {mode_wdata, own_slave_address, slave_address_mask, d} = 26'h0000000;
        timer1_fast_clock = 1'b1;
        timer1_reload_byte = 8'hFF;
        {error_cnt, cmp_count, cyc, ovf_cnt, ovr_cnt, mode, k, hold_rd, keep_done} = 0;
        seed = 34;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check("reset", {rx_done_flag, serial_buffer}, 9'h000);
        set_mode(2);
        multiproc_enable <= 1'b1;
        frame(8'h5A, 1'b1, 1'b1, 1'b1);
        frame(8'hA5, 1'b0, 1'b1, 1'b0);
        set_addr(8'hC0, 8'hFD);
        frame(8'hC2, 1'b1, 1'b1, 1'b1);
        frame(8'hC1, 1'b1, 1'b1, 1'b0);
        frame(8'hFD, 1'b1, 1'b1, 1'b1);
        multiproc_enable <= 1'b0;
        frame(8'h3C, 1'b0, 1'b1, 1'b1);
        multiproc_enable <= 1'b1;
        frame(8'h3C, 1'b0, 1'b1, 1'b0);
        for (k = 0; k < 6; k = k + 1) begin
            set_addr($random(seed), $random(seed));
            d = $random(seed);
            if (k[0])
                d = (own_slave_address & slave_address_mask) | (d & ~slave_address_mask);
            frame(d, 1'b1, 1'b1, addr_ok(d));
        end
        // Held receive-done blocks the next load
        multiproc_enable <= 1'b0;
        frame(8'h11, 1'b0, 1'b1, 1'b1);
        keep_done = 1;
        frame(8'h22, 1'b1, 1'b1, 1'b0);
        check("held", {rx_ninth_bit, serial_buffer}, 9'h011);
        keep_done = 0;
        for (k = 0; k < 8; k = k + 1) begin
            baud_double <= $random(seed);
            timer1_fast_clock <= $random(seed);
            @(posedge clk);
            timer1_reload_byte <= 8'hFF - {7'h00, timer1_fast_clock & k[1]};
            set_mode(2 + k[0]);
            frame($random(seed), $random(seed), 1'b1, 1'b1);
        end
        // Far side stalls until the buffer refuses, then drains it
        baud_double <= 1'b1;
        set_mode(2);
        hold_rd = 1;
        for (k = 0; k < 18; k = k + 1)
            frame($random(seed), $random(seed), 1'b1, 1'b1);
        check("overrun", ovr_cnt > 0, 9'h001);
        hold_rd = 0;
        repeat (200) @(posedge clk);
        check("drained", exp_q.size(), 9'h000);
        // Framing errors, sticky flag and the shared control bit
        {timer1_fast_clock, timer1_reload_byte, frame_err_enable} <= 10'h3FF;
        set_addr(8'h00, 8'h00);
        set_mode(1);
        frame(8'h96, 1'b0, 1'b0, 1'b1);
        check("fe_set", {frame_err_flag, ctl_bit7_rdata}, 9'h003);
        frame(8'h69, 1'b0, 1'b1, 1'b1);
        multiproc_enable <= 1'b1;
        frame(8'h0F, 1'b0, 1'b0, 1'b0);
        frame(8'hF0, 1'b0, 1'b1, 1'b1);
        check("fe_kept", frame_err_flag, 9'h001);
        clear_fe;
        check("fe_clear", {frame_err_flag, ctl_bit7_rdata}, 9'h000);
        multiproc_enable <= 1'b0;
        set_mode(2);
        frame(8'hE7, 1'b1, 1'b0, 1'b1);
        check("fe_nine", frame_err_flag, 9'h001);
        clear_fe;
        frame_err_enable <= 1'b0;
        repeat (2) @(posedge clk);
        check("bit7_mode", {frame_err_flag, ctl_bit7_rdata}, 9'h001);
        tally_and_finish;
    end
endmodule
